// file: verilog/cfm_pkg.sv
// Shared constants and carrier types of the crystal frequency monitor
package cfm_pkg;
	// Module base in the device map; the slave decodes offsets only
	localparam logic [7:0]  CFM_BASE_ADDR      = 8'h58;
	localparam logic [7:0]  CFM_OFS_ST_CFG     = 8'h00;
	localparam logic [7:0]  CFM_OFS_DRIFT_CFG  = 8'h04;
	localparam logic [7:0]  CFM_OFS_EVT_STS    = 8'h08;
	localparam logic [7:0]  CFM_OFS_EVT_MASK   = 8'h0C;
	localparam logic [7:0]  CFM_OFS_LIVE_STS   = 8'h10;

	localparam int          CFM_CNT_W          = 16;
	localparam int          CFM_UPPER_MSB      = 31;
	localparam int          CFM_UPPER_LSB      = 24;
	localparam int          CFM_LOWER_MSB      = 23;
	localparam int          CFM_LOWER_LSB      = 16;
	localparam int          CFM_WIN_MSB        = 11;
	localparam int          CFM_WIN_LSB        = 0;
	localparam int          CFM_FAULT_MSB      = 15;
	localparam int          CFM_FAULT_LSB      = 8;
	localparam int          CFM_CAUTION_MSB    = 7;
	localparam int          CFM_CAUTION_LSB    = 0;

	localparam logic [31:0] CFM_ST_CFG_RST     = 32'h0000_0000;
	localparam logic [31:0] CFM_ST_CFG_WMASK   = 32'hFFFF_0FFF;
	localparam logic [15:0] CFM_DRIFT_CFG_RST  = 16'h0000;
	localparam logic [3:0]  CFM_EVT_RST        = 4'h0;
	localparam logic [3:0]  CFM_MASK_RST       = 4'h0;

	// Event bit positions, shared by status and mask
	localparam int          CFM_EVT_ST0        = 0;
	localparam int          CFM_EVT_ST1        = 1;
	localparam int          CFM_EVT_DRIFT      = 2;
	localparam int          CFM_EVT_CAUTION    = 3;
	localparam int          CFM_EVT_W          = 4;

	// Calibration clock is the oscillator divided by this figure
	localparam int          CFM_CAL_DIV        = 16;
	// Drift limits count in this many ppm per lsb
	localparam logic [1:0]  CFM_PPM_PER_LSB    = 2'h2;
	localparam logic [19:0] CFM_PPM_SCALE      = 20'hF4240;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} cfm_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} cfm_apb_rsp_type;
endpackage

// file: verilog/cfm_edge_counter.sv
// Pin synchroniser, rising edge detector and clearable edge counter
`timescale 1ns/1ps
`default_nettype none
module cfm_edge_counter
	import cfm_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 sys_rst_i,
	input  wire logic                 sig_i,
	input  wire logic                 clear_i,
	output logic [CFM_CNT_W-1:0]      count_o
);
	typedef struct packed {
		logic [1:0]           sync;
		logic                 last;
		logic [CFM_CNT_W-1:0] count;
	} cfm_ec_state_type;

	cfm_ec_state_type cur_ff;
	cfm_ec_state_type nxt_cur;
	logic             rise;

	// Only sync[1] is looked at; sync[0] may be metastable
	assign rise = cur_ff.sync[1] & ~cur_ff.last;

	always_comb begin
		nxt_cur      = cur_ff;
		nxt_cur.sync = {cur_ff.sync[0], sig_i};
		nxt_cur.last = cur_ff.sync[1];
		// An edge in the clearing cycle opens the new window
		if (clear_i) begin
			nxt_cur.count = rise ? CFM_CNT_W'(1) : '0;
		end else if (rise && (cur_ff.count != '1)) begin
			nxt_cur.count = cur_ff.count + CFM_CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign count_o = cur_ff.count;
endmodule
`default_nettype wire

// file: verilog/cfm_monitor.sv
// Crystal frequency monitor: window timing, checks and APB registers
//
// Behaviour
// - Window end: crystal versus feedback difference checked
// - Fault only if other crystal below lower
// - Unusable flag holds while crystal out-of-limit
// - Upper limit zero disables short-term monitor
// - Window is programmed count of calibration edges
// - Window length zero disables short-term monitor
// - Inter-crystal difference above fault limit flags drift
// - Above caution, not above fault: caution
// - Drift limits are two ppm per lsb
// - Zero drift limit disables that check
// - Config registers at offsets 0x0, 0x4
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cfm_monitor
	import cfm_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	input  wire cfm_apb_req_type  apb_req_i,
	output cfm_apb_rsp_type       apb_rsp_o,
	input  wire logic             crystal0_clk_i,
	input  wire logic             crystal1_clk_i,
	input  wire logic             feedback_clk_i,
	input  wire logic             cal_clk_i,
	output logic                  crystal0_short_term_fault_o,
	output logic                  crystal1_short_term_fault_o,
	output logic                  drift_fault_o,
	output logic                  drift_caution_o,
	output logic [1:0]            crystal_unusable_o,
	output logic                  irq_o
);
	typedef struct packed {
		logic [31:0]          st_cfg;
		logic [15:0]          drift_cfg;
		logic [CFM_EVT_W-1:0] evt;
		logic [CFM_EVT_W-1:0] mask;
		logic [1:0]           unusable;
		logic [1:0]           over;
		logic [CFM_CNT_W-1:0] last_diff;
		logic [31:0]          prdata;
		logic                 pslverr;
		logic                 irq;
	} cfm_state_type;

	cfm_state_type        cur_ff;
	cfm_state_type        nxt_cur;

	// Every check starts disabled, so reset leaves the monitor idle
	localparam cfm_state_type CFM_STATE_RST = '{
		st_cfg:    CFM_ST_CFG_RST,
		drift_cfg: CFM_DRIFT_CFG_RST,
		evt:       CFM_EVT_RST,
		mask:      CFM_MASK_RST,
		unusable:  2'b00,
		over:      2'b00,
		last_diff: '0,
		prdata:    32'h0000_0000,
		pslverr:   1'b0,
		irq:       1'b0
	};

	logic [CFM_CNT_W-1:0] cnt_x0;
	logic [CFM_CNT_W-1:0] cnt_x1;
	logic [CFM_CNT_W-1:0] cnt_fb;
	logic [CFM_CNT_W-1:0] cnt_cal;
	logic                 clear_cnt;
	logic                 win_end;
	logic                 win_run;
	logic                 st_en;
	logic                 fault_en;
	logic                 caution_en;
	logic [7:0]           upper;
	logic [7:0]           lower;
	logic [11:0]          win_len;
	logic [7:0]           fault_lim;
	logic [7:0]           caution_lim;
	logic [CFM_CNT_W-1:0] diff0;
	logic [CFM_CNT_W-1:0] diff1;
	logic [CFM_CNT_W-1:0] diff_x;
	logic                 over0;
	logic                 over1;
	logic                 under0;
	logic                 under1;
	logic                 drift_over;
	logic                 caution_over;
	logic                 setup_ph;
	logic                 wr_acc;

	function automatic logic [CFM_CNT_W-1:0] abs_diff(
		input logic [CFM_CNT_W-1:0] a,
		input logic [CFM_CNT_W-1:0] b
	);
		return (a >= b) ? (a - b) : (b - a);
	endfunction

	// Limits are 8 bits wide; distances are counter wide
	function automatic logic above_lim(
		input logic [CFM_CNT_W-1:0] diff,
		input logic [7:0]           lim
	);
		return diff > CFM_CNT_W'(lim);
	endfunction

	function automatic logic below_lim(
		input logic [CFM_CNT_W-1:0] diff,
		input logic [7:0]           lim
	);
		return diff < CFM_CNT_W'(lim);
	endfunction

	// Unusable holds until a window shows the crystal within limit
	function automatic logic next_unusable(
		input logic cur,
		input logic st_on,
		input logic at_end,
		input logic fault,
		input logic over
	);
		logic n;
		n = cur;
		if (!st_on) begin
			n = 1'b0;
		end else if (at_end && fault) begin
			n = 1'b1;
		end else if (at_end && !over) begin
			n = 1'b0;
		end
		return n;
	endfunction

	// Crystal 0 is the reference, so a dead crystal 0 trips on any drift
	// Division-free ppm test: diff/ref > lim*lsb  <=>  diff*1e6 > lim*lsb*ref
	// Forty bits hold a full counter times a million without overflow
	function automatic logic ppm_over(
		input logic [CFM_CNT_W-1:0] diff,
		input logic [CFM_CNT_W-1:0] ref_cnt,
		input logic [7:0]           lim
	);
		logic [39:0] lhs;
		logic [39:0] rhs;
		lhs = 40'(diff) * 40'(CFM_PPM_SCALE);
		rhs = 40'(lim) * 40'(CFM_PPM_PER_LSB) * 40'(ref_cnt);
		return lhs > rhs;
	endfunction

	function automatic logic [31:0] read_word(
		input logic [7:0]  addr,
		input cfm_state_type s
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (addr)
			CFM_OFS_ST_CFG: begin
				w = s.st_cfg & CFM_ST_CFG_WMASK;
			end
			CFM_OFS_DRIFT_CFG: begin
				w = {16'h0000, s.drift_cfg};
			end
			CFM_OFS_EVT_STS: begin
				w = {28'h0000000, s.evt};
			end
			CFM_OFS_EVT_MASK: begin
				w = {28'h0000000, s.mask};
			end
			CFM_OFS_LIVE_STS: begin
				w = {s.last_diff, 12'h000, s.over, s.unusable};
			end
			default: begin
				w = 32'h0000_0000;
			end
		endcase
		return w;
	endfunction

	function automatic logic addr_ok(input logic [7:0] addr);
		return (addr == CFM_OFS_ST_CFG) || (addr == CFM_OFS_DRIFT_CFG) ||
			(addr == CFM_OFS_EVT_STS) || (addr == CFM_OFS_EVT_MASK) ||
			(addr == CFM_OFS_LIVE_STS);
	endfunction

	// Pin clocks need one clock high and one low, or edges are lost
	// counters per window
	cfm_edge_counter u_cnt_x0 (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.sig_i     (crystal0_clk_i),
		.clear_i   (clear_cnt),
		.count_o   (cnt_x0)
	);

	cfm_edge_counter u_cnt_x1 (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.sig_i     (crystal1_clk_i),
		.clear_i   (clear_cnt),
		.count_o   (cnt_x1)
	);

	cfm_edge_counter u_cnt_fb (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.sig_i     (feedback_clk_i),
		.clear_i   (clear_cnt),
		.count_o   (cnt_fb)
	);

	cfm_edge_counter u_cnt_cal (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.sig_i     (cal_clk_i),
		.clear_i   (clear_cnt),
		.count_o   (cnt_cal)
	);

	assign upper       = cur_ff.st_cfg[CFM_UPPER_MSB:CFM_UPPER_LSB];
	assign lower       = cur_ff.st_cfg[CFM_LOWER_MSB:CFM_LOWER_LSB];
	assign win_len     = cur_ff.st_cfg[CFM_WIN_MSB:CFM_WIN_LSB];
	assign fault_lim   = cur_ff.drift_cfg[CFM_FAULT_MSB:CFM_FAULT_LSB];
	assign caution_lim = cur_ff.drift_cfg[CFM_CAUTION_MSB:CFM_CAUTION_LSB];

	assign win_run = (win_len != 12'h000);
	assign win_end = win_run && (cnt_cal >= {4'h0, win_len});
	// clear at window boundary and while idle
	assign clear_cnt = win_end | ~win_run;

	assign st_en      = win_run && (upper != 8'h00);
	assign fault_en   = win_run && (fault_lim != 8'h00);
	assign caution_en = win_run && (caution_lim != 8'h00);

	assign diff0  = abs_diff(cnt_x0, cnt_fb);
	assign diff1  = abs_diff(cnt_x1, cnt_fb);
	assign over0  = above_lim(diff0, upper);
	assign over1  = above_lim(diff1, upper);
	assign under0 = below_lim(diff0, lower);
	assign under1 = below_lim(diff1, lower);

	// limits scaled at two ppm per lsb against crystal 0
	assign diff_x       = abs_diff(cnt_x0, cnt_x1);
	assign drift_over   = ppm_over(diff_x, cnt_x0, fault_lim);
	assign caution_over = ppm_over(diff_x, cnt_x0, caution_lim);

	// Setup is seen a cycle ahead of access; the slave never stalls
	assign setup_ph = apb_req_i.psel & ~apb_req_i.penable;
	assign wr_acc   = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;

	always_comb begin
		logic [CFM_EVT_W-1:0] set_evt;
		logic [1:0]           fault_now;
		set_evt   = '0;
		fault_now = 2'b00;
		nxt_cur   = cur_ff;

		if (win_end) begin
			nxt_cur.over      = {over1, over0};
			nxt_cur.last_diff = diff_x;
			// fault needs the other crystal in range
			if (st_en) begin
				fault_now[0] = over0 & under1;
				fault_now[1] = over1 & under0;
			end
			set_evt[CFM_EVT_ST0] = fault_now[0];
			set_evt[CFM_EVT_ST1] = fault_now[1];
			set_evt[CFM_EVT_DRIFT] = fault_en & drift_over;
			set_evt[CFM_EVT_CAUTION] = caution_en & caution_over &
				~(fault_en & drift_over);
		end

		// unusable until back within the upper limit
		nxt_cur.unusable[0] = next_unusable(cur_ff.unusable[0], st_en,
			win_end, fault_now[0], over0);
		nxt_cur.unusable[1] = next_unusable(cur_ff.unusable[1], st_en,
			win_end, fault_now[1], over1);

		// Register writes take effect in the access phase
		if (wr_acc) begin
			case (apb_req_i.paddr)
				// configuration words at 0x0 and 0x4
				CFM_OFS_ST_CFG: begin
					nxt_cur.st_cfg = apb_req_i.pwdata & CFM_ST_CFG_WMASK;
				end
				CFM_OFS_DRIFT_CFG: begin
					nxt_cur.drift_cfg = apb_req_i.pwdata[15:0];
				end
				CFM_OFS_EVT_STS: begin
					nxt_cur.evt = cur_ff.evt &
						~apb_req_i.pwdata[CFM_EVT_W-1:0];
				end
				CFM_OFS_EVT_MASK: begin
					nxt_cur.mask = apb_req_i.pwdata[CFM_EVT_W-1:0];
				end
				default: begin
					nxt_cur.mask = cur_ff.mask;
				end
			endcase
		end

		// A new event beats a same-cycle write-one-to-clear
		nxt_cur.evt = nxt_cur.evt | set_evt;
		// Registered so the interrupt pin cannot glitch
		nxt_cur.irq = |(nxt_cur.evt & nxt_cur.mask);

		// Read data captured in setup so it sits in a flop for access
		if (setup_ph) begin
			nxt_cur.prdata  = apb_req_i.pwrite ? 32'h0000_0000 :
				read_word(apb_req_i.paddr, cur_ff);
			nxt_cur.pslverr = ~addr_ok(apb_req_i.paddr);
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cur_ff <= CFM_STATE_RST;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// Zero-wait slave: every access completes in its first access cycle
	assign apb_rsp_o = '{
		prdata:  cur_ff.prdata,
		pready:  1'b1,
		pslverr: cur_ff.pslverr
	};

	assign crystal0_short_term_fault_o = cur_ff.evt[CFM_EVT_ST0];
	assign crystal1_short_term_fault_o = cur_ff.evt[CFM_EVT_ST1];
	assign drift_fault_o               = cur_ff.evt[CFM_EVT_DRIFT];
	assign drift_caution_o             = cur_ff.evt[CFM_EVT_CAUTION];
	assign crystal_unusable_o          = cur_ff.unusable;
	assign irq_o                       = cur_ff.irq;
endmodule
`default_nettype wire

// file: testbench/cfm_monitor_asserts.sv
// Port checker for the crystal frequency monitor
`timescale 1ns/1ps
`default_nettype none
module cfm_monitor_chk
	import cfm_pkg::*;
(
	input wire logic            clk_i,
	input wire logic            sys_rst_i,
	input wire cfm_apb_req_type apb_req_i,
	input wire cfm_apb_rsp_type apb_rsp_o,
	input wire logic            crystal0_short_term_fault_o,
	input wire logic            crystal1_short_term_fault_o,
	input wire logic            drift_fault_o,
	input wire logic            drift_caution_o,
	input wire logic [1:0]      crystal_unusable_o,
	input wire logic            irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic setup;
	logic clr_wr;
	assign setup = apb_req_i.psel & ~apb_req_i.penable;
	assign clr_wr = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite
		& (apb_req_i.paddr == CFM_OFS_EVT_STS);

	a_ready_high: assert property (apb_rsp_o.pready)
		else $error("pready low");
	a_unmap_err: assert property (setup && apb_req_i.paddr > 8'h13
		|=> apb_rsp_o.pslverr) else $error("no error on unmapped");
	a_map_ok: assert property (setup && apb_req_i.paddr == 8'h00
		|=> !apb_rsp_o.pslverr) else $error("error on config");
	a_irq_cause: assert property (irq_o |-> (crystal0_short_term_fault_o
		|| crystal1_short_term_fault_o || drift_fault_o || drift_caution_o))
		else $error("irq without event");
	a_unus0_fault: assert property ($rose(crystal_unusable_o[0])
		|-> crystal0_short_term_fault_o) else $error("unusable0 alone");
	a_unus1_fault: assert property ($rose(crystal_unusable_o[1])
		|-> crystal1_short_term_fault_o) else $error("unusable1 alone");
	a_caution_excl: assert property ($rose(drift_caution_o)
		|-> !$rose(drift_fault_o)) else $error("caution with fault");
	a_c0_sticky: assert property ($fell(crystal0_short_term_fault_o)
		|-> $past(clr_wr && apb_req_i.pwdata[0])) else $error("fault0 lost");
	a_drift_sticky: assert property ($fell(drift_fault_o)
		|-> $past(clr_wr && apb_req_i.pwdata[2])) else $error("drift lost");
endmodule
bind cfm_monitor cfm_monitor_chk cfm_monitor_chk_i (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o),
	.crystal0_short_term_fault_o(crystal0_short_term_fault_o),
	.crystal1_short_term_fault_o(crystal1_short_term_fault_o),
	.drift_fault_o(drift_fault_o), .drift_caution_o(drift_caution_o),
	.crystal_unusable_o(crystal_unusable_o), .irq_o(irq_o));
`default_nettype wire

// file: testbench/cfm_monitor_tb.sv
// Self-checking bench for the crystal frequency monitor
`timescale 1ns/1ps
`default_nettype none
module cfm_monitor_tb
	import cfm_pkg::*;
;
	logic            clk_i = 1'b0;
	logic            sys_rst_i = 1'b1;
	logic            sel = 1'b0;
	cfm_apb_req_type req = '0;
	cfm_apb_rsp_type rsp;
	logic            f0, f1, df, dc, irq;
	logic [1:0]      unus;
	logic [7:0]      tick = 8'h00;
	logic [31:0]     rnd = 32'h38;
	logic [32:0]     expq[$];
	int              mismatches = 0;
	int              checks = 0;
	wire logic [6:0] flg = {irq, unus, dc, df, f1, f0};
	// Fast pin runs at twice the feedback rate; sel swaps the crystals
	wire logic       c0 = sel ? tick[2] : tick[1];
	wire logic       c1 = sel ? tick[1] : tick[2];

	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) tick <= tick + 8'h01;

	cfm_monitor cfm_monitor_i (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.apb_req_i(req), .apb_rsp_o(rsp),
		.crystal0_clk_i(c0), .crystal1_clk_i(c1),
		.feedback_clk_i(tick[2]), .cal_clk_i(tick[4]),
		.crystal0_short_term_fault_o(f0),
		.crystal1_short_term_fault_o(f1),
		.drift_fault_o(df), .drift_caution_o(dc),
		.crystal_unusable_o(unus), .irq_o(irq));

	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction

	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk_i);
		req.penable <= 1'b1;
		do @(posedge clk_i); while (rsp.pready !== 1'b1);
		req <= '0;
		@(posedge clk_i);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic e);
		expq.push_back({d, e});
		apb(1'b0, a, 32'h0);
	endtask

	task automatic fl(input logic [6:0] e);
		@(negedge clk_i);
		chk({26'h0, flg}, {26'h0, e});
		@(posedge clk_i);
	endtask

	task automatic until_hi(input int b);
		for (int i = 0; i < 900 && flg[b] !== 1'b1; i++)
			@(posedge clk_i);
		repeat (4) @(posedge clk_i);
	endtask

	// Read data is taken at the access edge, in issue order
	always @(posedge clk_i)
		if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite)
			chk({rsp.prdata, rsp.pslverr}, expq.pop_front());

	initial begin
		#100000;
		mismatches++;
		final_report();
	end

	initial begin
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		rd(CFM_OFS_ST_CFG, 32'h0, 1'b0);
		rd(CFM_OFS_DRIFT_CFG, 32'h0, 1'b0);
		rd(8'h14, 32'h0, 1'b1);
		// Live status ignores writes and reads zero after reset
		apb(1'b1, CFM_OFS_LIVE_STS, 32'hFFFF_FFFF);
		rd(CFM_OFS_LIVE_STS, 32'h0, 1'b0);
		rnd = xs(rnd);
		// Window kept zero so random limits cannot start the monitor
		apb(1'b1, CFM_OFS_ST_CFG, rnd & 32'hFFFF_F000);
		rd(CFM_OFS_ST_CFG, rnd & 32'hFFFF_0000, 1'b0);
		rnd = xs(rnd);
		apb(1'b1, CFM_OFS_DRIFT_CFG, rnd);
		rd(CFM_OFS_DRIFT_CFG, {16'h0, rnd[15:0]}, 1'b0);
		apb(1'b1, CFM_OFS_EVT_MASK, 32'hF);
		rd(CFM_OFS_EVT_MASK, 32'hF, 1'b0);
		apb(1'b1, CFM_OFS_DRIFT_CFG, 32'h100);
		apb(1'b1, CFM_OFS_ST_CFG, 32'h0404_0004);
		until_hi(0);
		fl(7'h55);
		rd(CFM_OFS_EVT_STS, 32'h5, 1'b0);
		apb(1'b1, CFM_OFS_EVT_MASK, 32'h0);
		apb(1'b1, CFM_OFS_ST_CFG, 32'h0);
		fl(7'h05);
		apb(1'b1, CFM_OFS_EVT_STS, 32'hF);
		rd(CFM_OFS_EVT_STS, 32'h0, 1'b0);
		sel <= 1'b1;
		apb(1'b1, CFM_OFS_DRIFT_CFG, 32'h1);
		apb(1'b1, CFM_OFS_ST_CFG, 32'h0404_0004);
		until_hi(1);
		fl(7'h2A);
		apb(1'b1, CFM_OFS_ST_CFG, 32'h0);
		apb(1'b1, CFM_OFS_EVT_STS, 32'hF);
		apb(1'b1, CFM_OFS_ST_CFG, 32'h0004_0004);
		repeat (400) @(posedge clk_i);
		fl(7'h08);
		// Mid-run reset with caution up: every field back to zero
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		fl(7'h00);
		rd(CFM_OFS_ST_CFG, 32'h0, 1'b0);
		rd(CFM_OFS_DRIFT_CFG, 32'h0, 1'b0);
		apb(1'b1, CFM_OFS_DRIFT_CFG, 32'h1);
		apb(1'b1, CFM_OFS_ST_CFG, 32'h0404_0000);
		apb(1'b1, CFM_OFS_EVT_STS, 32'hF);
		repeat (400) @(posedge clk_i);
		fl(7'h00);
		rd(CFM_OFS_EVT_STS, 32'h0, 1'b0);
		final_report();
	end
endmodule
`default_nettype wire
